// ===== include/cicdc_pkg.sv
// Purpose: constants shared by the dual-channel cic filter design
// Assumes: build settings below are fixed at elaboration
// Notes:   output width uses a per-stage ceiling of log2(r*m)
package cicdc_pkg;

  // ----------------------------------------------------------------
  // build settings
  // ----------------------------------------------------------------
  localparam int CICDC_DECIM = 1;        // 1 decimator, 0 interpolator
  localparam int CICDC_CHANNELS = 2;     // channel_count, 1 or 2
  localparam int CICDC_STAGES = 4;       // stage_count
  localparam int CICDC_RATE = 10;        // rate change factor
  localparam int CICDC_DIFF_DELAY = 1;   // differential delay, 1 or 2
  localparam int CICDC_IN_W = 10;        // input sample width
  localparam int CICDC_OUT_W =
    CICDC_STAGES * $clog2(CICDC_RATE * CICDC_DIFF_DELAY) + CICDC_IN_W;
  localparam int CICDC_CNT_W = 14;
  localparam logic [CICDC_CNT_W-1:0] CICDC_RATE_LAST =
    CICDC_CNT_W'(CICDC_RATE - 1);
  localparam bit CICDC_PARAMS_OK =
    (CICDC_CHANNELS == 1 || (CICDC_CHANNELS == 2 && CICDC_DECIM == 1)) &&
    CICDC_STAGES >= 1 && CICDC_STAGES <= 8 &&
    CICDC_RATE >= 4 && CICDC_RATE <= 16383 &&
    (CICDC_DIFF_DELAY == 1 || CICDC_DIFF_DELAY == 2) &&
    CICDC_IN_W >= 1 && CICDC_IN_W <= 32 &&
    (CICDC_DECIM == 0 || CICDC_DECIM == 1);

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  localparam int CICDC_FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CICDC_REG_CTRL = 8'h00;
  localparam logic [7:0] CICDC_REG_STATUS = 8'h04;
  localparam logic [7:0] CICDC_REG_COUNT = 8'h08;
  localparam logic [7:0] CICDC_REG_CONFIG = 8'h0c;
  localparam int CICDC_CTRL_RUN_BIT = 0;
  localparam int CICDC_CTRL_PHASE_BIT = 1;
  localparam logic [1:0] CICDC_CTRL_RESET = 2'h1;
  localparam int CICDC_STAT_LEVEL_LSB = 0;
  localparam int CICDC_STAT_PHASE_BIT = 8;
  localparam int CICDC_STAT_FULL_BIT = 9;
  localparam int CICDC_STAT_EMPTY_BIT = 10;
  localparam int CICDC_STAT_BUSY_BIT = 11;
  localparam int CICDC_CFG_RATE_LSB = 0;
  localparam int CICDC_CFG_STAGES_LSB = 16;
  localparam int CICDC_CFG_CHAN_LSB = 20;
  localparam int CICDC_CFG_DELAY_LSB = 22;
  localparam int CICDC_CFG_DECIM_BIT = 24;

  typedef enum logic {CICDC_IDLE, CICDC_RUN} cicdc_state_t;

endpackage

// ===== src/cicdc_fifo.sv
// Purpose: sample buffer between the source and the filter
// Assumes: one clock, synchronous active-low reset
// Notes:   read data always come from the output register
`timescale 1ns/1ps
module cicdc_fifo
  import cicdc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // fill level of the storage array
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] cnt, next_cnt;
  logic [WIDTH-1:0] next_out_data;
  logic next_out_valid, push, load;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign level = cnt;

  always_comb begin
    push = in_valid && in_ready;
    load = (cnt != '0) && (!out_valid || out_ready);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);
    next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_out_data = load ? mem[rd_ptr] : out_data;
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      cnt <= next_cnt;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule

// ===== src/cicdc_filter.sv
// Purpose: cic decimator or interpolator with optional dual channel
// Assumes: build settings from cicdc_pkg, 250 MHz clk_sys
// Notes:   input samples pass a 16-word buffer; results full precision
//
// Summary of operation
// - dual channel time-shares one arithmetic datapath
// - channel_count is one or two, decimator only
// - interpolator always processes a single stream
// - sample taken only with sample_valid_in high
// - dual results leave in input channel order
// - dual result_valid spans two consecutive cycles when the channel 1 sample is taken in the next cycle
// - dual pair every two times r accepted samples
// - stage_count one to eight, n integrators, n combs
// - rate factor four to 16383
// - filter type selects decimator or interpolator
// - differential delay one or two
// - input width one to 32 bits
// - every stage carries full grown width
// - single channel result every r accepted samples
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module cicdc_filter
  import cicdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sample input
  input wire logic [CICDC_IN_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic accept_ready,
  // result output
  output logic [CICDC_OUT_W-1:0] result_out,
  output logic result_valid,
  output logic result_channel,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int N = CICDC_STAGES;
  localparam int M = CICDC_DIFF_DELAY;
  localparam int W = CICDC_OUT_W;
  localparam int C = CICDC_CHANNELS;
  localparam int LW = $clog2(CICDC_FIFO_DEPTH) + 1;

  typedef logic [W-1:0] cicdc_word_t;

  function automatic cicdc_word_t cicdc_sext(
    input logic [CICDC_IN_W-1:0] x
  );
    cicdc_word_t r;
    r = {{(W-CICDC_IN_W){x[CICDC_IN_W-1]}}, x};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  logic [CICDC_IN_W-1:0] buf_data;
  logic buf_valid, take;
  logic [LW-1:0] buf_level;

  cicdc_fifo #(
    .WIDTH(CICDC_IN_W),
    .DEPTH(CICDC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_data(sample_in),
    .in_valid(sample_valid_in),
    .in_ready(accept_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(take),
    .level(buf_level)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl, next_ctrl;
  logic [31:0] res_count, next_res_count;
  logic [31:0] next_reg_rdata;
  logic run, phase_clear;

  assign run = ctrl[CICDC_CTRL_RUN_BIT];
  assign phase_clear = reg_wr && (reg_addr == CICDC_REG_CTRL) &&
                       reg_wdata[CICDC_CTRL_PHASE_BIT];

  // ----------------------------------------------------------------
  // datapath state
  // ----------------------------------------------------------------
  cicdc_word_t integ [C][N];
  cicdc_word_t next_integ [C][N];
  cicdc_word_t dly [C][N][M];
  cicdc_word_t next_dly [C][N][M];
  cicdc_word_t comb_hold, next_comb_hold;
  cicdc_word_t next_result_out;
  logic next_result_valid, next_result_channel;
  logic chan, next_chan;
  logic [CICDC_CNT_W-1:0] dcnt, next_dcnt;
  cicdc_state_t state, next_state;
  logic first, next_first;

  always_comb begin
    cicdc_word_t v;
    logic ch;
    v = '0;
    ch = 1'b0;
    next_integ = integ;
    next_dly = dly;
    next_comb_hold = comb_hold;
    next_result_out = result_out;
    next_result_valid = 1'b0;
    next_result_channel = result_channel;
    next_chan = chan;
    next_dcnt = dcnt;
    next_state = state;
    next_first = first;
    take = 1'b0;
    if (CICDC_DECIM == 1) begin
      take = buf_valid && run;
      // one datapath, state selected by channel
      ch = (C == 2) ? chan : 1'b0;
      if (take) begin
        next_integ[ch][0] = integ[ch][0] + cicdc_sext(buf_data);
        for (int s = 1; s < N; s++) begin
          next_integ[ch][s] = integ[ch][s] + integ[ch][s-1];
        end
        if (C == 2) begin
          next_chan = ~chan;
        end
        // one result per r samples per channel
        if (dcnt == CICDC_RATE_LAST) begin
          v = next_integ[ch][N-1];
          for (int s = 0; s < N; s++) begin
            next_dly[ch][s][0] = v;
            for (int d = 1; d < M; d++) begin
              next_dly[ch][s][d] = dly[ch][s][d-1];
            end
            v = v - dly[ch][s][M-1];
          end
          // one-cycle valid, tagged with its channel
          next_result_out = v;
          next_result_valid = 1'b1;
          next_result_channel = ch;
        end
        if (C == 1 || chan) begin
          next_dcnt = (dcnt == CICDC_RATE_LAST) ? '0 : dcnt + 1'b1;
        end
      end
      if (phase_clear) begin
        next_chan = 1'b0;
      end
    end else begin
      // interpolator, single stream, r outputs per input
      case (state)
        CICDC_IDLE: begin
          take = buf_valid && run;
        end
        CICDC_RUN: begin
          take = buf_valid && run && (dcnt == CICDC_RATE_LAST);
        end
        default: begin
          take = 1'b0;
        end
      endcase
      if (take) begin
        v = cicdc_sext(buf_data);
        for (int s = 0; s < N; s++) begin
          next_dly[0][s][0] = v;
          for (int d = 1; d < M; d++) begin
            next_dly[0][s][d] = dly[0][s][d-1];
          end
          v = v - dly[0][s][M-1];
        end
        next_comb_hold = v;
        next_first = 1'b1;
      end
      if (state == CICDC_RUN) begin
        next_integ[0][0] = integ[0][0] + (first ? comb_hold : '0);
        for (int s = 1; s < N; s++) begin
          next_integ[0][s] = integ[0][s] + next_integ[0][s-1];
        end
        next_result_out = next_integ[0][N-1];
        next_result_valid = 1'b1;
        next_result_channel = 1'b0;
        if (!take) begin
          next_first = 1'b0;
        end
        if (dcnt == CICDC_RATE_LAST) begin
          next_dcnt = '0;
          if (!take) begin
            next_state = CICDC_IDLE;
          end
        end else begin
          next_dcnt = dcnt + 1'b1;
        end
      end else if (take) begin
        next_state = CICDC_RUN;
        next_dcnt = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int c = 0; c < C; c++) begin
        for (int s = 0; s < N; s++) begin
          integ[c][s] <= '0;
          for (int d = 0; d < M; d++) begin
            dly[c][s][d] <= '0;
          end
        end
      end
      comb_hold <= '0;
      result_out <= '0;
      result_valid <= 1'b0;
      result_channel <= 1'b0;
      chan <= 1'b0;
      dcnt <= '0;
      state <= CICDC_IDLE;
      first <= 1'b0;
    end else begin
      integ <= next_integ;
      dly <= next_dly;
      comb_hold <= next_comb_hold;
      result_out <= next_result_out;
      result_valid <= next_result_valid;
      result_channel <= next_result_channel;
      chan <= next_chan;
      dcnt <= next_dcnt;
      state <= next_state;
      first <= next_first;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_res_count = res_count + 32'(result_valid);
    next_reg_rdata = '0;
    if (reg_wr && reg_addr == CICDC_REG_CTRL) begin
      next_ctrl = {1'b0, reg_wdata[CICDC_CTRL_RUN_BIT]};
    end else if (reg_wr && reg_addr == CICDC_REG_COUNT) begin
      next_res_count = 32'(result_valid);
    end
    if (reg_rd && reg_addr == CICDC_REG_CTRL) begin
      next_reg_rdata[CICDC_CTRL_RUN_BIT] = run;
    end else if (reg_rd && reg_addr == CICDC_REG_STATUS) begin
      next_reg_rdata[CICDC_STAT_LEVEL_LSB +: LW] = buf_level;
      next_reg_rdata[CICDC_STAT_PHASE_BIT] = chan;
      next_reg_rdata[CICDC_STAT_FULL_BIT] = ~accept_ready;
      next_reg_rdata[CICDC_STAT_EMPTY_BIT] = ~buf_valid;
      next_reg_rdata[CICDC_STAT_BUSY_BIT] = (state == CICDC_RUN);
    end else if (reg_rd && reg_addr == CICDC_REG_COUNT) begin
      next_reg_rdata = res_count;
    end else if (reg_rd && reg_addr == CICDC_REG_CONFIG) begin
      next_reg_rdata[CICDC_CFG_RATE_LSB +: 14] = 14'(CICDC_RATE);
      next_reg_rdata[CICDC_CFG_STAGES_LSB +: 4] = 4'(N);
      next_reg_rdata[CICDC_CFG_CHAN_LSB +: 2] = 2'(C);
      next_reg_rdata[CICDC_CFG_DELAY_LSB +: 2] = 2'(M);
      next_reg_rdata[CICDC_CFG_DECIM_BIT] = 1'(CICDC_DECIM);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= CICDC_CTRL_RESET;
      res_count <= '0;
      reg_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      res_count <= next_res_count;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic last_ch;
  logic [CICDC_CNT_W:0] gap;
  logic seen;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      last_ch <= 1'b1;
      gap <= '0;
      seen <= 1'b0;
    end else begin
      if (result_valid) begin
        last_ch <= result_channel;
      end
      if (result_valid && !result_channel) begin
        gap <= (CICDC_CNT_W+1)'(take);
        seen <= 1'b1;
      end else if (take) begin
        gap <= gap + 1'b1;
      end
    end
  end

  sequence s_ch0_out;
    result_valid && !result_channel;
  endsequence

  sequence s_ch1_out;
    result_valid && result_channel;
  endsequence

  a_param_legal:
    assert property (@(posedge clk_sys) CICDC_PARAMS_OK)
    else $error("illegal build settings");

  a_width_grown:
    assert property (@(posedge clk_sys)
      W == N * $clog2(CICDC_RATE * M) + CICDC_IN_W)
    else $error("datapath width not full growth");

  a_take_gated:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |-> buf_valid && run)
    else $error("sample taken without valid data");

  a_chan_toggle:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (C == 2 && CICDC_DECIM == 1 && take && !phase_clear)
      |=> chan != $past(chan))
    else $error("channel did not toggle on accept");

  a_pair_order:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      result_valid && C == 2 |-> result_channel != last_ch)
    else $error("dual results out of channel order");

  a_pair_back:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_ch0_out ##0 (C == 2 && take && chan) |=> s_ch1_out)
    else $error("second channel result not adjacent");

  a_result_gap:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_ch0_out ##0 (seen && CICDC_DECIM == 1)
      |-> $past(gap) == (CICDC_CNT_W+1)'(CICDC_RATE * C - 1))
    else $error("result spacing wrong");

  a_hold_output:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      !result_valid |-> $stable(result_out))
    else $error("output changed without valid");

  a_interp_single:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (CICDC_DECIM == 0 && state == CICDC_RUN)
      |=> result_valid && !result_channel)
    else $error("interpolator missed an output");
endmodule

// ===== bench/cicdc_source.sv
// Purpose: upstream sample source model for the cic filter bench
// Assumes: first sample after a phase origin belongs to channel 0
// Notes:   idle bus shows an inverted, toggling copy of the last value
`timescale 1ns/1ps
module cicdc_source
  import cicdc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // sample port
  output logic [CICDC_IN_W-1:0] sample_in,
  output logic sample_valid_in,
  input wire logic accept_ready
);
  initial begin
    sample_in = '0;
    sample_valid_in = 1'b0;
  end

  task automatic send(input logic [CICDC_IN_W-1:0] a,
                      input logic [CICDC_IN_W-1:0] b,
                      input int n, input int gap_max);
    logic ok;
    for (int i = 0; i < n; i++) begin
      sample_valid_in <= 1'b1;
      sample_in <= i[0] ? b : a;
      // ready is settled at the falling edge
      do begin
        @(negedge clk_sys);
        ok = accept_ready;
        @(posedge clk_sys);
      end while (ok !== 1'b1);
      repeat ($urandom_range(gap_max)) begin
        sample_valid_in <= 1'b0;
        sample_in <= ~sample_in;
        @(posedge clk_sys);
      end
    end
    sample_valid_in <= 1'b0;
    sample_in <= ~sample_in;
  endtask
endmodule

// ===== bench/tb_cicdc_filter.sv
// Purpose: self-checking bench for the dual-channel cic decimator
// Assumes: package build settings, dc input per channel
// Notes:   dc settles to input times (r*m)**n, so phase does not matter
`timescale 1ns/1ps
module tb_cicdc_filter;
  import cicdc_pkg::*;

  typedef struct packed {
    logic care;
    logic ch;
    logic [CICDC_OUT_W-1:0] val;
  } cicdc_note_t;

  localparam int GAIN = (CICDC_RATE * CICDC_DIFF_DELAY) ** CICDC_STAGES;
  localparam int WARM = 6;
  localparam int TIMEOUT_NS = 40000;

  logic clk_sys;
  logic rst_n;
  logic [CICDC_IN_W-1:0] sample_in;
  logic sample_valid_in;
  logic accept_ready;
  logic [CICDC_OUT_W-1:0] result_out;
  logic result_valid;
  logic result_channel;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int last0 = 0;
  bit cont = 0;
  bit live = 0;
  bit rd_prev = 0;
  logic prev_v = 0;
  logic prev_ch = 0;
  logic [CICDC_OUT_W-1:0] prev_out = '0;
  cicdc_note_t notes[$];
  cicdc_note_t nt;
  logic [31:0] rexp[$];

  cicdc_filter u_cicdc_filter (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .sample_in(sample_in), .sample_valid_in(sample_valid_in),
    .accept_ready(accept_ready),
    .result_out(result_out), .result_valid(result_valid),
    .result_channel(result_channel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  cicdc_source u_cicdc_source (
    .clk_sys(clk_sys), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .accept_ready(accept_ready)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_res(input logic [CICDC_OUT_W-1:0] got,
                         input logic [CICDC_OUT_W-1:0] exp);
    cmp_reg(32'(got), 32'(exp));
  endtask

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    rexp.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic run_dc(input int pairs, input int gap);
    logic [CICDC_IN_W-1:0] a;
    logic [CICDC_IN_W-1:0] b;
    a = CICDC_IN_W'($urandom);
    b = CICDC_IN_W'($urandom);
    last0 = 0;
    for (int p = 0; p < pairs; p++) begin
      notes.push_back('{p >= WARM, 1'b0, CICDC_OUT_W'($signed(a) * GAIN)});
      notes.push_back('{p >= WARM, 1'b1, CICDC_OUT_W'($signed(b) * GAIN)});
    end
    u_cicdc_source.send(a, b, 2 * CICDC_RATE * pairs, gap);
  endtask

  task automatic drain();
    for (int k = 0; k < 1000 && notes.size() > 0; k++) @(posedge clk_sys);
    cmp_reg(32'(notes.size()), 32'h0);
  endtask

  // ------------------------------------------------------------
  // output monitor
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    cyc++;
    if (rd_prev) begin
      cmp_reg(reg_rdata, rexp.pop_front());
    end
    rd_prev = (reg_rd === 1'b1);
    if (result_valid === 1'b1) begin
      nt = (notes.size() > 0) ? notes.pop_front() :
           cicdc_note_t'{1'b0, 1'bx, '0};
      cmp_reg(32'(result_channel), 32'(nt.ch));
      if (nt.care) begin
        cmp_res(result_out, nt.val);
      end
      if (cont && result_channel === 1'b1) begin
        cmp_reg(32'({prev_v, prev_ch}), 32'h2);
      end
      if (cont && result_channel === 1'b0 && last0 > 0) begin
        cmp_reg(32'(cyc - last0), 32'(2 * CICDC_RATE));
      end
      if (result_channel === 1'b0) begin
        last0 = cyc;
      end
    end else if (live && rst_n === 1'b1) begin
      cmp_res(result_out, prev_out);
    end
    live = (rst_n === 1'b1);
    prev_out = result_out;
    prev_v = result_valid;
    prev_ch = result_channel;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(54));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    reg_read(CICDC_REG_CTRL, 32'h1);
    reg_read(CICDC_REG_CONFIG, 32'(CICDC_RATE)
      | (32'(CICDC_STAGES) << CICDC_CFG_STAGES_LSB)
      | (32'(CICDC_CHANNELS) << CICDC_CFG_CHAN_LSB)
      | (32'(CICDC_DIFF_DELAY) << CICDC_CFG_DELAY_LSB)
      | (32'(CICDC_DECIM) << CICDC_CFG_DECIM_BIT));
    reg_read(8'h10, 32'h0);
    reg_read(CICDC_REG_STATUS, 32'h400);
    // continuous dual-channel stream
    cont = 1;
    run_dc(12, 0);
    drain();
    cont = 0;
    // stalled filter fills the buffer, then drains
    reg_write(CICDC_REG_CTRL, 32'h0);
    fork
      run_dc(12, 2);
      begin
        for (int k = 0; k < 300 && accept_ready !== 1'b0; k++) begin
          @(negedge clk_sys);
        end
        @(posedge clk_sys);
        reg_read(CICDC_REG_STATUS, 32'h210);
        reg_write(CICDC_REG_CTRL, 32'h1);
      end
    join
    drain();
    // result counter and its clear
    reg_read(CICDC_REG_COUNT, 32'd48);
    reg_write(CICDC_REG_COUNT, 32'h5a5a);
    reg_read(CICDC_REG_COUNT, 32'h0);
    // lone sample flips the phase, phase clear restores it
    u_cicdc_source.send(CICDC_IN_W'($urandom), '0, 1, 0);
    repeat (4) @(posedge clk_sys);
    reg_read(CICDC_REG_STATUS, 32'h500);
    reg_write(CICDC_REG_CTRL, 32'h3);
    reg_read(CICDC_REG_STATUS, 32'h400);
    reg_read(CICDC_REG_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys);
    end_sim();
  end

  initial begin
    #(TIMEOUT_NS);
    miscompares++;
    end_sim();
  end
endmodule
